// ==== src/rst_seq_pkg.sv ====
// reset and power-on sequencer: shared constants and types
// assumes a single core_clk domain at 50 MHz; rtc tick arrives as a one-cycle pulse
package rst_seq_pkg;

  localparam int unsigned CLK_HZ          = 50000000;
  localparam int unsigned HALT_TIME_S     = 4;
  localparam int unsigned HALT_CYCLES     = HALT_TIME_S * CLK_HZ;

  // register map (own layout, word addresses in bytes)
  localparam logic [7:0] CTRL_ADDR     = 8'h00;
  localparam logic [7:0] STATUS_ADDR   = 8'h04;
  localparam logic [7:0] DEADMAN_ADDR  = 8'h08;
  localparam logic [7:0] CAUSE_ADDR    = 8'h0C;
  localparam logic [7:0] CORE_SR_ADDR  = 8'h10;
  localparam logic [7:0] RANDOM_ADDR   = 8'h14;
  localparam logic [7:0] WIRED_ADDR    = 8'h18;
  localparam logic [7:0] CONFIG_ADDR   = 8'h1C;
  localparam logic [7:0] VECTOR_ADDR   = 8'h20;

  // ctrl register fields
  localparam int unsigned CTRL_DM_EN_BIT   = 0;
  localparam int unsigned CTRL_DM_CLR_BIT  = 1;
  localparam int unsigned CTRL_HALT_CLR    = 2;
  localparam int unsigned CTRL_SHUTDOWN    = 3;

  // core status register fields
  localparam int unsigned SR_ERL_BIT  = 2;
  localparam int unsigned SR_SR_BIT   = 20;
  localparam int unsigned SR_TS_BIT   = 21;
  localparam int unsigned SR_BEV_BIT  = 22;

  localparam logic [4:0]  RANDOM_RESET = 5'h1F;
  localparam logic [4:0]  WIRED_RESET  = 5'h00;
  localparam logic [19:0] CONFIG_MID_RESET = 20'h04800;

  // reset vector and exception vectors, bootstrap and normal
  localparam logic [31:0] RESET_VEC32 = 32'hBFC00000;
  localparam logic [63:0] BEV_TLB_VEC = 64'hFFFFFFFFBFC00200;
  localparam logic [63:0] BEV_GEN_VEC = 64'hFFFFFFFFBFC00380;
  localparam logic [63:0] TLB_VEC     = 64'hFFFFFFFF80000000;
  localparam logic [63:0] GEN_VEC     = 64'hFFFFFFFF80000180;

  // power-on handshake and deadman period, in rtc ticks
  localparam logic [2:0] SAMPLE_TICKS  = 3'h3;
  localparam logic [2:0] ABORT_TICKS   = 3'h1;
  localparam logic [2:0] RELEASE_TICKS = 3'h4;
  localparam logic [15:0] DEADMAN_RESET = 16'hFFFF;

  // cause codes reported in the cause register
  localparam logic [2:0] CAUSE_POR      = 3'h0;
  localparam logic [2:0] CAUSE_SWITCH   = 3'h1;
  localparam logic [2:0] CAUSE_DEADMAN  = 3'h2;
  localparam logic [2:0] CAUSE_SHUTDOWN = 3'h3;
  localparam logic [2:0] CAUSE_HALT     = 3'h4;

  typedef enum logic [2:0] {
    PWR_OFF     = 3'b000,
    PWR_RAISE   = 3'b001,
    PWR_HOLD    = 3'b011,
    PWR_RUN     = 3'b010,
    PWR_ABORT   = 3'b110
  } pwr_state_e;

  typedef struct packed {
    logic power_switch;
    logic carrier_detect;
    logic wake_alarm;
  } start_cause_s;

  typedef struct packed {
    logic battery_inhibit_input;
    logic battery_lock_input;
  } battery_s;

endpackage

// ==== src/reset_and_power_on_sequencer.sv ====
// reset and power-on sequencer: gathers reset sources, core reset values and
// the power-on handshake with external battery circuitry
// assumes inputs synchronous to core_clk; rtc_tick is a one-cycle pulse per rtc period
`timescale 1ns/10ps
`default_nettype none

module reset_and_power_on_sequencer #(
  parameter int unsigned HALT_CYCLES = rst_seq_pkg::HALT_CYCLES
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic                      rtc_tick,
  // reset sources
  input  wire logic                      power_on_reset_input,
  input  wire logic                      reset_switch_input,
  input  wire logic                      deep_sleep_exec,
  // start causes and battery pins
  input  wire rst_seq_pkg::start_cause_s start_cause,
  input  wire rst_seq_pkg::battery_s     battery,
  // power pins
  output logic                           power_on_indicator,
  output logic                           main_power_output,
  output logic                           dram_self_refresh,
  // core side
  output logic                           core_reset,
  output logic                           bus_master,
  output logic [31:0]                    fetch_addr,
  output logic [63:0]                    tlb_vector,
  output logic [63:0]                    gen_vector,
  // register port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [31:0]               reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic [31:0]                    reg_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  logic        wr_ctrl;
  logic        dm_en_q;
  logic        dm_clear;
  logic        halt_clear;
  logic        sw_shutdown;
  logic [15:0] dm_period_q;

  assign wr_ctrl     = reg_wr && (reg_addr == rst_seq_pkg::CTRL_ADDR);
  assign dm_clear    = wr_ctrl && reg_wdata[rst_seq_pkg::CTRL_DM_CLR_BIT];
  assign halt_clear  = wr_ctrl && reg_wdata[rst_seq_pkg::CTRL_HALT_CLR];
  assign sw_shutdown = (wr_ctrl && reg_wdata[rst_seq_pkg::CTRL_SHUTDOWN]) || deep_sleep_exec;

  logic        sys_rst_q;
  logic        pmu_rst;
  rst_seq_pkg::pwr_state_e pwr_q;
  rst_seq_pkg::pwr_state_e pwr_prev_q;
  assign pmu_rst = rst || power_on_reset_input;

  // deadman enable and period live with the pmu, so a system reset keeps them
  always_ff @(posedge core_clk) begin
    if (pmu_rst) begin
      dm_en_q     <= 1'b0;
      dm_period_q <= rst_seq_pkg::DEADMAN_RESET;
    end else begin
      if (wr_ctrl)
        dm_en_q <= reg_wdata[rst_seq_pkg::CTRL_DM_EN_BIT];
      if (reg_wr && reg_addr == rst_seq_pkg::DEADMAN_ADDR)
        dm_period_q <= reg_wdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // deadman timer, counted in rtc ticks

  logic [15:0] dm_cnt_q;
  logic        dm_fire;

  assign dm_fire = dm_en_q && rtc_tick && (dm_cnt_q >= dm_period_q);

  always_ff @(posedge core_clk) begin
    if (pmu_rst || sys_rst_q || !dm_en_q || dm_clear)
      dm_cnt_q <= 16'h0000;
    else if (rtc_tick)
      dm_cnt_q <= dm_cnt_q + 16'h0001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt timer: runs once after power-on reset, stopped by software

  logic [31:0] halt_cnt_q;
  logic        halt_armed_q;
  logic        halt_fire;

  assign halt_fire = halt_armed_q && (halt_cnt_q == HALT_CYCLES[31:0] - 32'h1);

  always_ff @(posedge core_clk) begin
    if (pmu_rst) begin
      halt_cnt_q   <= 32'h0;
      halt_armed_q <= 1'b1;
    end else if (halt_clear || halt_fire) begin
      halt_cnt_q   <= 32'h0;
      halt_armed_q <= 1'b0;
    end else if (halt_armed_q) begin
      halt_cnt_q <= halt_cnt_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shutdown: self-refresh rises first, main power drops in the same cycle as the reset

  logic shut_q;

  always_ff @(posedge core_clk) begin
    if (pmu_rst)
      shut_q <= 1'b0;
    else if (sw_shutdown)
      shut_q <= 1'b1;
    // main power coming back ends self-refresh; clearing only in run would send the core straight back off
    else if (pwr_q == rst_seq_pkg::PWR_HOLD && pwr_prev_q != rst_seq_pkg::PWR_HOLD)
      shut_q <= 1'b0;
  end

  assign dram_self_refresh = shut_q;

  ////////////////////////////////////////////////////////////////////////////
  // combined system reset, one flop so core sees a clean level

  logic sys_req;
  logic [2:0] cause_q;

  // power-on reset clears everything, the rest spare the pmu state
  assign sys_req = pmu_rst || reset_switch_input || dm_fire || halt_fire
                   || shut_q || (pwr_q != rst_seq_pkg::PWR_RUN);

  always_ff @(posedge core_clk) begin
    if (rst)
      sys_rst_q <= 1'b1;
    else
      sys_rst_q <= sys_req;
  end

  always_ff @(posedge core_clk) begin
    if (rst || power_on_reset_input)
      cause_q <= rst_seq_pkg::CAUSE_POR;
    else if (reset_switch_input)
      cause_q <= rst_seq_pkg::CAUSE_SWITCH;
    else if (dm_fire)
      cause_q <= rst_seq_pkg::CAUSE_DEADMAN;
    else if (sw_shutdown)
      cause_q <= rst_seq_pkg::CAUSE_SHUTDOWN;
    else if (halt_fire)
      cause_q <= rst_seq_pkg::CAUSE_HALT;
  end

  assign core_reset = sys_rst_q;
  assign bus_master = !sys_rst_q;

  ////////////////////////////////////////////////////////////////////////////
  // power-on handshake on rtc ticks

  logic [2:0]              tick_cnt_q;
  logic                    any_start;
  logic                    batt_ok;

  assign any_start = start_cause.power_switch || start_cause.carrier_detect
                     || start_cause.wake_alarm;
  assign batt_ok   = battery.battery_inhibit_input && battery.battery_lock_input;

  always_ff @(posedge core_clk) begin
    if (pmu_rst) begin
      pwr_q      <= rst_seq_pkg::PWR_OFF;
      tick_cnt_q <= 3'h0;
    end else begin
      case (pwr_q)
        rst_seq_pkg::PWR_OFF: begin
          tick_cnt_q <= 3'h0;
          if (any_start)
            pwr_q <= rst_seq_pkg::PWR_RAISE;
        end
        rst_seq_pkg::PWR_RAISE: begin
          if (rtc_tick) begin
            if (tick_cnt_q == rst_seq_pkg::SAMPLE_TICKS - 3'h1) begin
              tick_cnt_q <= 3'h0;
              pwr_q <= batt_ok ? rst_seq_pkg::PWR_HOLD : rst_seq_pkg::PWR_ABORT;
            end else begin
              tick_cnt_q <= tick_cnt_q + 3'h1;
            end
          end
        end
        rst_seq_pkg::PWR_HOLD: begin
          if (rtc_tick) begin
            if (tick_cnt_q == rst_seq_pkg::RELEASE_TICKS - 3'h1) begin
              tick_cnt_q <= 3'h0;
              pwr_q      <= rst_seq_pkg::PWR_RUN;
            end else begin
              tick_cnt_q <= tick_cnt_q + 3'h1;
            end
          end
        end
        rst_seq_pkg::PWR_ABORT: begin
          if (rtc_tick && tick_cnt_q == rst_seq_pkg::ABORT_TICKS - 3'h1)
            pwr_q <= rst_seq_pkg::PWR_OFF;
          else if (rtc_tick)
            tick_cnt_q <= tick_cnt_q + 3'h1;
        end
        rst_seq_pkg::PWR_RUN: begin
          // shutdown returns to off; later start causes restart the handshake
          if (shut_q)
            pwr_q <= rst_seq_pkg::PWR_OFF;
        end
        default: pwr_q <= rst_seq_pkg::PWR_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (pmu_rst)
      pwr_prev_q <= rst_seq_pkg::PWR_OFF;
    else
      pwr_prev_q <= pwr_q;
  end

  always_ff @(posedge core_clk) begin
    if (pmu_rst) begin
      power_on_indicator <= 1'b0;
      main_power_output  <= 1'b0;
    end else begin
      power_on_indicator <= (pwr_q == rst_seq_pkg::PWR_RAISE) || (pwr_q == rst_seq_pkg::PWR_HOLD)
                            || (pwr_q == rst_seq_pkg::PWR_ABORT);
      main_power_output  <= (pwr_q == rst_seq_pkg::PWR_HOLD || pwr_q == rst_seq_pkg::PWR_RUN)
                            && !shut_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core register reset values

  logic        bev_q;
  logic        erl_q;
  logic        ts_q;
  logic        srf_q;
  logic [4:0]  random_q;
  logic [4:0]  wired_q;
  logic [31:0] config_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst_q) begin
      ts_q  <= 1'b0;
      srf_q <= 1'b0;
      erl_q <= 1'b1;
      bev_q <= 1'b1;
    end else if (reg_wr && reg_addr == rst_seq_pkg::CORE_SR_ADDR) begin
      ts_q  <= reg_wdata[rst_seq_pkg::SR_TS_BIT];
      srf_q <= reg_wdata[rst_seq_pkg::SR_SR_BIT];
      erl_q <= reg_wdata[rst_seq_pkg::SR_ERL_BIT];
      bev_q <= reg_wdata[rst_seq_pkg::SR_BEV_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst_q)
      random_q <= rst_seq_pkg::RANDOM_RESET;
    else if (random_q == wired_q)
      random_q <= rst_seq_pkg::RANDOM_RESET;
    else
      random_q <= random_q - 5'h01;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst_q)
      wired_q <= rst_seq_pkg::WIRED_RESET;
    else if (reg_wr && reg_addr == rst_seq_pkg::WIRED_ADDR)
      wired_q <= reg_wdata[4:0];
  end

  // undefined config bits are held at zero for determinism
  always_ff @(posedge core_clk) begin
    if (sys_rst_q)
      config_q <= {4'h0, 5'h00, rst_seq_pkg::CONFIG_MID_RESET, 3'h0};
    else if (reg_wr && reg_addr == rst_seq_pkg::CONFIG_ADDR)
      config_q <= {4'h0, reg_wdata[27:0]};
  end

  assign fetch_addr = rst_seq_pkg::RESET_VEC32;
  assign tlb_vector = bev_q ? rst_seq_pkg::BEV_TLB_VEC : rst_seq_pkg::TLB_VEC;
  assign gen_vector = bev_q ? rst_seq_pkg::BEV_GEN_VEC : rst_seq_pkg::GEN_VEC;

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        rst_seq_pkg::CTRL_ADDR:    reg_rdata <= {31'h0, dm_en_q};
        rst_seq_pkg::STATUS_ADDR:  reg_rdata <= {25'h0, pwr_q, shut_q, halt_armed_q, sys_rst_q, main_power_output};
        rst_seq_pkg::DEADMAN_ADDR: reg_rdata <= {16'h0, dm_period_q};
        rst_seq_pkg::CAUSE_ADDR:   reg_rdata <= {29'h0, cause_q};
        rst_seq_pkg::CORE_SR_ADDR: reg_rdata <= {9'h0, bev_q, ts_q, srf_q, 17'h0, erl_q, 2'h0};
        rst_seq_pkg::RANDOM_ADDR:  reg_rdata <= {27'h0, random_q};
        rst_seq_pkg::WIRED_ADDR:   reg_rdata <= {27'h0, wired_q};
        rst_seq_pkg::CONFIG_ADDR:  reg_rdata <= config_q;
        rst_seq_pkg::VECTOR_ADDR:  reg_rdata <= fetch_addr;
        default:                   reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  bev_after_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sys_rst_q) |-> bev_q && erl_q && !ts_q && !srf_q)
    else $error("status flags wrong after reset");

  random_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sys_rst_q) |-> random_q == 5'h1F)
    else $error("random not 31 after reset");

  wired_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sys_rst_q) |-> wired_q == 5'h00)
    else $error("wired not zero after reset");

  config_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(sys_rst_q) |-> config_q[22:3] == 20'h04800 && config_q[31:28] == 4'h0)
    else $error("config reset value wrong");

  switch_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    reset_switch_input |=> sys_rst_q && !bus_master)
    else $error("switch did not reset");

  shutdown_power_a: assert property (@(posedge core_clk) disable iff (pmu_rst)
    sw_shutdown |=> dram_self_refresh ##1 !main_power_output && sys_rst_q)
    else $error("shutdown order wrong");

  abort_drop_a: assert property (@(posedge core_clk) disable iff (pmu_rst)
    pwr_q == rst_seq_pkg::PWR_ABORT && rtc_tick |-> ##2 !power_on_indicator)
    else $error("indicator not dropped on abort");

  start_raise_a: assert property (@(posedge core_clk) disable iff (pmu_rst)
    pwr_q == rst_seq_pkg::PWR_OFF && any_start |-> ##2 power_on_indicator)
    else $error("indicator not raised on start");

  vector_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    bev_q |-> tlb_vector == 64'hFFFFFFFFBFC00200 && gen_vector == 64'hFFFFFFFFBFC00380)
    else $error("bootstrap vectors wrong");

  halt_fire_a: assert property (@(posedge core_clk) disable iff (pmu_rst)
    halt_fire |=> sys_rst_q)
    else $error("halt timeout did not reset");

  start_ok_c:  cover property (@(posedge core_clk) pwr_q == rst_seq_pkg::PWR_HOLD ##1 pwr_q == rst_seq_pkg::PWR_RUN);
  start_bad_c: cover property (@(posedge core_clk) pwr_q == rst_seq_pkg::PWR_ABORT);
  deadman_c:   cover property (@(posedge core_clk) dm_fire);

endmodule

`default_nettype wire

// ==== sim/battery_model.sv ====
// partner model: external power supply and battery monitor on the power-on handshake
// assumes rtc_tick is a one-cycle pulse in the core_clk domain
`timescale 1ns/10ps
`default_nettype none

module battery_model (
  // clock and rtc tick
  input  wire logic                  core_clk,
  input  wire logic                  rtc_tick,
  // handshake pins
  input  wire logic                  power_on_indicator,
  input  wire logic [1:0]            allow,
  output var  rst_seq_pkg::battery_s battery,
  // rtc ticks seen while the indicator stood high
  output var  logic [3:0]            on_ticks
);
  logic ind_prev = 1'b0;
  logic tick_prev = 1'b0;

  // a low level on either pin blocks start-up; both high lets it go ahead
  always_comb begin
    battery = rst_seq_pkg::battery_s'(allow);
  end

  // counting restarts on each rise so every handshake is measured alone
  always_ff @(posedge core_clk) begin
    ind_prev  <= power_on_indicator;
    tick_prev <= rtc_tick;
    // a tick on the edge that raises the indicator already counts inside the sequencer
    if (power_on_indicator && !ind_prev) begin
      on_ticks <= {3'h0, rtc_tick | tick_prev};
    end else if (power_on_indicator && rtc_tick) begin
      on_ticks <= on_ticks + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ==== sim/reset_and_power_on_sequencer_bench.sv ====
// bench for the reset and power-on sequencer: start handshakes, reset sources, core reset values
// assumes the battery model in its own file and rtc ticks made here from core_clk
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) check(64'(g), 64'(e))

module reset_and_power_on_sequencer_bench;
  localparam int HALT_SIM = 100;
  // shortened rtc period keeps the run short; the handshake counts in ticks, not cycles
  localparam int TICK_DIV = 64;
  localparam int LIMIT    = 40000;
  typedef struct packed {logic [2:0] cause; logic [1:0] batt; logic via_ctrl;} row_s;
  row_s rows [6] = '{6'b100110, 6'b010010, 6'b010111, 6'b001100, 6'b001110, 6'b100000};

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic rtc_tick = 1'b0;
  logic por = 1'b0;
  logic rsw = 1'b0;
  logic deep_sleep_exec = 1'b0;
  logic [1:0] allow = 2'b11;
  rst_seq_pkg::start_cause_s start_cause = '0;
  rst_seq_pkg::battery_s battery;
  logic power_on_indicator, main_power_output, dram_self_refresh, core_reset, bus_master;
  logic [31:0] fetch_addr;
  logic [63:0] tlb_vector, gen_vector;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [3:0] on_ticks;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int tick_cnt = 0;
  logic [31:0] d;

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
    rtc_tick <= (tick_cnt == TICK_DIV - 1);
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      $display("MISMATCH at %0t: timeout got %h exp %h", $time, cycles, LIMIT);
      test_done();
    end
  end

  reset_and_power_on_sequencer #(.HALT_CYCLES(HALT_SIM)) dut (
    .core_clk(core_clk), .rst(rst), .rtc_tick(rtc_tick), .power_on_reset_input(por),
    .reset_switch_input(rsw), .deep_sleep_exec(deep_sleep_exec), .start_cause(start_cause),
    .battery(battery), .power_on_indicator(power_on_indicator), .main_power_output(main_power_output),
    .dram_self_refresh(dram_self_refresh), .core_reset(core_reset), .bus_master(bus_master),
    .fetch_addr(fetch_addr), .tlb_vector(tlb_vector), .gen_vector(gen_vector), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  battery_model partner (
    .core_clk(core_clk), .rtc_tick(rtc_tick), .power_on_indicator(power_on_indicator),
    .allow(allow), .battery(battery), .on_ticks(on_ticks));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask

  task automatic wait_sig(input int sel, input logic val, input int lim);
    int n;
    n = 0;
    @(negedge core_clk);
    while ((sel == 0 ? power_on_indicator : core_reset) !== val && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(sel == 0 ? power_on_indicator : core_reset, val);
  endtask

  task automatic check_core();
    logic [31:0] v;
    reg_read(rst_seq_pkg::CORE_SR_ADDR, v);
    `CHK(v[rst_seq_pkg::SR_TS_BIT], 1'b0);
    `CHK(v[rst_seq_pkg::SR_SR_BIT], 1'b0);
    `CHK(v[rst_seq_pkg::SR_ERL_BIT], 1'b1);
    `CHK(v[rst_seq_pkg::SR_BEV_BIT], 1'b1);
    reg_read(rst_seq_pkg::WIRED_ADDR, v);
    `CHK(v[4:0], 5'h00);
    reg_read(rst_seq_pkg::CONFIG_ADDR, v);
    `CHK(v[31:28], 4'h0);
    `CHK(v[22:3], 20'h04800);
    reg_read(rst_seq_pkg::VECTOR_ADDR, v);
    `CHK(v, 32'hBFC00000);
    `CHK(fetch_addr, 32'hBFC00000);
    `CHK(tlb_vector, 64'hFFFFFFFFBFC00200);
    `CHK(gen_vector, 64'hFFFFFFFFBFC00380);
    reg_read(8'hFC, v);
    `CHK(v, 32'h00000000);
  endtask

  task automatic run_row(input row_s r, input logic shut);
    logic ok;
    logic [31:0] v;
    ok = (r.batt == 2'b11);
    @(posedge core_clk);
    allow <= r.batt;
    start_cause <= rst_seq_pkg::start_cause_s'(r.cause);
    wait_sig(0, 1'b1, 10);
    @(posedge core_clk);
    start_cause <= '0;
    wait_sig(0, 1'b0, 12 * TICK_DIV);
    `CHK(on_ticks, ok ? 4'h7 : 4'h4);
    repeat (4) @(negedge core_clk);
    `CHK(core_reset, !ok);
    `CHK(bus_master, ok);
    `CHK(main_power_output, ok);
    `CHK(dram_self_refresh, !ok);
    if (ok) begin
      check_core();
    end
    if (ok && shut) begin
      if (r.via_ctrl) begin
        reg_write(rst_seq_pkg::CTRL_ADDR, 32'h00000008);
      end else begin
        @(posedge core_clk);
        deep_sleep_exec <= 1'b1;
        @(posedge core_clk);
        deep_sleep_exec <= 1'b0;
      end
      wait_sig(1, 1'b1, 50);
      `CHK(dram_self_refresh, 1'b1);
      `CHK(main_power_output, 1'b0);
      // random free-runs once the core is out of reset, so it is only checked while reset holds
      reg_read(rst_seq_pkg::RANDOM_ADDR, v);
      `CHK(v[4:0], 5'h1F);
      reg_read(rst_seq_pkg::CAUSE_ADDR, v);
      `CHK(v[2:0], rst_seq_pkg::CAUSE_SHUTDOWN);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // a cleared halt timer must stay quiet past its period
    reg_write(rst_seq_pkg::CTRL_ADDR, 32'h00000004);
    repeat (HALT_SIM + 50) @(posedge core_clk);
    reg_read(rst_seq_pkg::CAUSE_ADDR, d);
    `CHK(d[2:0], rst_seq_pkg::CAUSE_POR);
    `CHK(core_reset, 1'b1);
    `CHK(dram_self_refresh, 1'b0);
    reg_read(rst_seq_pkg::RANDOM_ADDR, d);
    `CHK(d[4:0], 5'h1F);
    foreach (rows[i]) begin
      run_row(rows[i], 1'b1);
    end
    run_row(6'b100110, 1'b0);
    // deadman: serviced in time, then left alone
    reg_write(rst_seq_pkg::DEADMAN_ADDR, 32'h00000003);
    repeat (8) begin
      reg_write(rst_seq_pkg::CTRL_ADDR, 32'h00000003);
      repeat (TICK_DIV / 2) @(posedge core_clk);
    end
    `CHK(core_reset, 1'b0);
    reg_write(rst_seq_pkg::CTRL_ADDR, 32'h00000001);
    wait_sig(1, 1'b1, 6 * TICK_DIV);
    `CHK(dram_self_refresh, 1'b0);
    reg_write(rst_seq_pkg::CTRL_ADDR, 32'h00000000);
    reg_read(rst_seq_pkg::CAUSE_ADDR, d);
    `CHK(d[2:0], rst_seq_pkg::CAUSE_DEADMAN);
    wait_sig(1, 1'b0, 8 * TICK_DIV);
    // reset switch leaves the power state alone, so no new handshake
    @(posedge core_clk);
    rsw <= 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK(core_reset, 1'b1);
    `CHK(dram_self_refresh, 1'b0);
    @(posedge core_clk);
    rsw <= 1'b0;
    wait_sig(1, 1'b0, 200);
    `CHK(power_on_indicator, 1'b0);
    reg_read(rst_seq_pkg::CAUSE_ADDR, d);
    `CHK(d[2:0], rst_seq_pkg::CAUSE_SWITCH);
    check_core();
    // power-on reset from a running core, then an unserviced halt timer
    @(posedge core_clk);
    por <= 1'b1;
    repeat (3) @(negedge core_clk);
    `CHK(core_reset, 1'b1);
    `CHK(main_power_output, 1'b0);
    `CHK(dram_self_refresh, 1'b0);
    @(posedge core_clk);
    por <= 1'b0;
    reg_read(rst_seq_pkg::CAUSE_ADDR, d);
    `CHK(d[2:0], rst_seq_pkg::CAUSE_POR);
    repeat (HALT_SIM + 50) @(posedge core_clk);
    reg_read(rst_seq_pkg::CAUSE_ADDR, d);
    `CHK(d[2:0], rst_seq_pkg::CAUSE_HALT);
    test_done();
  end
endmodule

`default_nettype wire
